// file: logic/bwm_bridge.v
// byte-to-word mailbox bridge between an 8-bit controller bus and
// a 16-bit processor port
// assumes both sides share clk and nrst; strobes are single-cycle
`timescale 1ns/100ps
`include "bwm_defs.vh"
module bwm_bridge #(
  parameter FAULT_CYCLES = `BWM_FAULT_CYCLES,
  parameter TW           = 24
) (
  input  wire          clk,
  input  wire          nrst,
  // controller side
  input  wire [15:0]   mcuAddr,
  input  wire [7:0]    mcuWrData,
  input  wire          mcuSel,
  input  wire          mcuRdWr,
  output reg  [7:0]    mcuRdData,
  // processor side
  input  wire [15:0]   dspWrData,
  input  wire          dspWrStb,
  input  wire          dspRdStb,
  output reg  [15:0]   dspRdData,
  // status seen by both sides
  output wire          inReady,
  output wire          outReady,
  output wire          commFault,
  input  wire          faultClr,
  input  wire [TW-1:0] faultLimit
);
  reg [15:0] inWord_r;
  reg [15:0] outWord_r;
  reg [7:0]  outLo_r;
  reg        inRdy_r;
  reg        outRdy_r;
  reg        fault_r;
  wire       expired;

  // a zero limit falls back to the default wait
  wire [TW-1:0] dfltLimit = FAULT_CYCLES[TW-1:0];
  wire [TW-1:0] waitLimit = (faultLimit == {TW{1'b0}}) ? dfltLimit
                                                        : faultLimit;

  wire mcuRd   = mcuSel &  mcuRdWr;
  wire mcuWr   = mcuSel & ~mcuRdWr;
  wire selLo   = (mcuAddr == `BWM_ADDR_DATA_LO);
  wire selHi   = (mcuAddr == `BWM_ADDR_DATA_HI);
  wire selSt   = (mcuAddr == `BWM_ADDR_STATUS);
  wire hiRead  = mcuRd & selHi;
  wire hiWrite = mcuWr & selHi;

  // controller writes: low byte held, high byte completes the word
  always @(posedge clk) begin
    if (!nrst) begin
      outLo_r   <= 8'h00;
      outWord_r <= 16'h0000;
    end else begin
      if (mcuWr && selLo)
        outLo_r <= mcuWrData;
      if (hiWrite)
        outWord_r <= {mcuWrData, outLo_r};
    end
  end

  // processor deposit
  always @(posedge clk) begin
    if (!nrst)
      inWord_r <= 16'h0000;
    else if (dspWrStb)
      inWord_r <= dspWrData;
  end

  // flags: set wins over clear in the same cycle
  always @(posedge clk) begin
    if (!nrst) begin
      inRdy_r  <= 1'b0;
      outRdy_r <= 1'b0;
    end else begin
      if (dspWrStb)
        inRdy_r <= 1'b1;
      else if (hiRead)
        inRdy_r <= 1'b0;
      if (hiWrite)
        outRdy_r <= 1'b1;
      else if (dspRdStb)
        outRdy_r <= 1'b0;
    end
  end

  bwm_timer #(
    .WIDTH (TW)
  ) u_timer (
    .clk     (clk),
    .nrst    (nrst),
    .arm     (outRdy_r),
    .limit   (waitLimit),
    .expired (expired)
  );

  // fault is sticky until cleared; a new expiry wins over the clear
  always @(posedge clk) begin
    if (!nrst)
      fault_r <= 1'b0;
    else if (expired)
      fault_r <= 1'b1;
    else if (faultClr)
      fault_r <= 1'b0;
  end

  // controller read data
  always @(posedge clk) begin
    if (!nrst)
      mcuRdData <= 8'h00;
    else if (mcuRd) begin
      if (selLo)
        mcuRdData <= inWord_r[7:0];
      else if (selHi)
        mcuRdData <= inWord_r[15:8];
      else if (selSt) begin
        mcuRdData <= 8'h00;
        mcuRdData[`BWM_ST_INRDY]  <= inRdy_r;
        mcuRdData[`BWM_ST_OUTRDY] <= outRdy_r;
        mcuRdData[`BWM_ST_FAULT]  <= fault_r;
      end else
        mcuRdData <= 8'h00;
    end
  end

  // processor read data
  always @(posedge clk) begin
    if (!nrst)
      dspRdData <= 16'h0000;
    else if (dspRdStb)
      dspRdData <= outWord_r;
  end

  assign inReady   = inRdy_r;
  assign outReady  = outRdy_r;
  assign commFault = fault_r;
endmodule

// file: logic/bwm_defs.vh
// constants for the byte-to-word mailbox bridge
// assumes one system clock and a synchronous active-low reset
// Operation
// - byte controller exchanges whole words with processor
// - two ready flags seen by both sides
// - processor deposit raises inbound-ready flag
// - controller deposit raises outbound-ready flag
// - uncollected outbound word raises communication fault
`ifndef BWM_DEFS_VH
`define BWM_DEFS_VH
// controller address map, the full 16-bit address selects the byte
`define BWM_ADDR_DATA_LO 16'h0000
`define BWM_ADDR_DATA_HI 16'h0001
`define BWM_ADDR_STATUS  16'h0002
// status byte bit positions
`define BWM_ST_INRDY  0
`define BWM_ST_OUTRDY 1
`define BWM_ST_FAULT  2
// default fault wait in microseconds, clock period in ns
`define BWM_FAULT_WAIT_US 1000
`define BWM_CLK_NS        20
`define BWM_FAULT_CYCLES  ((`BWM_FAULT_WAIT_US * 1000) / `BWM_CLK_NS)
`endif

// file: logic/bwm_timer.v
// fault wait timer: counts while armed, flags once the limit is reached
// assumes arm and limit come from logic on the same clock
`timescale 1ns/100ps
module bwm_timer #(
  parameter WIDTH = 24
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             arm,
  input  wire [WIDTH-1:0] limit,
  output wire             expired
);
  reg [WIDTH-1:0] count_r;
  reg             expired_r;

  always @(posedge clk) begin
    if (!nrst || !arm) begin
      count_r   <= {WIDTH{1'b0}};
      expired_r <= 1'b0;
    end else if (count_r >= limit) begin
      expired_r <= 1'b1;
    end else begin
      count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign expired = expired_r;
endmodule

// file: bench/bwm_monitor.sv
// assertions on the ports of bwm_bridge
// assumes bind with .* from the bench top
`timescale 1ns/100ps
module bwm_monitor #(parameter TW=24) (
  input wire clk,nrst,mcuSel,mcuRdWr,dspWrStb,dspRdStb,
  input wire inReady,outReady,commFault,faultClr,
  input wire [15:0] mcuAddr,dspWrData,dspRdData,
  input wire [7:0] mcuWrData,mcuRdData,
  input wire [TW-1:0] faultLimit);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire hiWr = mcuSel && !mcuRdWr && mcuAddr == 16'h0001;
  wire hiRd = mcuSel && mcuRdWr && mcuAddr == 16'h0001;
  wire stRd = mcuSel && mcuRdWr && mcuAddr == 16'h0002;
  a_in_set: assert property (dspWrStb |=> inReady)
    else $error("inReady not set");
  a_out_set: assert property (hiWr |=> outReady)
    else $error("outReady not set");
  a_out_clr: assert property (dspRdStb && !hiWr |=> !outReady)
    else $error("outReady not cleared");
  a_in_clr: assert property (hiRd && !dspWrStb |=> !inReady)
    else $error("inReady not cleared");
  a_status_byte: assert property (stRd |=> mcuRdData ==
    {5'h00,$past(commFault),$past(outReady),$past(inReady)})
    else $error("status byte wrong");
  a_fault_cause: assert property ($rose(commFault) |-> $past(outReady,2))
    else $error("fault without waiting word");
  a_fault_sticky: assert property (commFault && !faultClr |=> commFault)
    else $error("fault dropped");
  a_in_cause: assert property ($rose(inReady) |-> $past(dspWrStb))
    else $error("inReady rose alone");
  cover property (commFault);
  cover property (hiRd);
  cover property (outReady && dspRdStb);
endmodule

// file: bench/bwm_dsp_model.sv
// processor side model: deposits and collects words
// assumes bench calls put and get between clock edges
`timescale 1ns/100ps
module bwm_dsp_model (input wire clk,outReady,input wire [15:0] dspRdData,
  output reg [15:0] dspWrData,output reg dspWrStb,dspRdStb);
  initial begin dspWrData=16'h0000; dspWrStb=0; dspRdStb=0; end
  task put(input [15:0] v); begin
    @(negedge clk) dspWrData=v; dspWrStb=1;
    @(negedge clk) dspWrStb=0; dspWrData=~v; end endtask
  task get(output [15:0] v); begin
    @(negedge clk) dspRdStb=1;
    @(negedge clk) dspRdStb=0; v=dspRdData; end endtask
endmodule

// file: bench/bwm_bridge_test.sv
// bench for bwm_bridge with the processor model
// assumes monitor and model are compiled first
`timescale 1ns/100ps
module bwm_bridge_test;
`define CHK(a,b) begin checks++; if((a)!==(b)) begin failures++; \
  $display("[FAIL] %0t mismatch",$time); end end
  reg clk=0,nrst=0,mcuSel=0,mcuRdWr=0,faultClr=0;
  reg [15:0] mcuAddr=16'h0000; reg [7:0] mcuWrData=8'h00;
  reg [23:0] faultLimit=24'h00000A;
  wire [7:0] mcuRdData; wire [15:0] dspWrData,dspRdData;
  wire dspWrStb,dspRdStb,inReady,outReady,commFault;
  integer failures=0,checks=0; reg [7:0] b; reg [15:0] w;
  always #10 clk=~clk;
  bwm_bridge i_bwm_bridge(.*);
  bwm_dsp_model i_bwm_dsp_model(.*);
  task acc(input [15:0] a,input rw,input [7:0] d); begin
    @(negedge clk) mcuAddr=a; mcuRdWr=rw; mcuWrData=d; mcuSel=1;
    @(negedge clk) mcuSel=0; b=mcuRdData; end endtask
  task t_out; begin
    acc(16'h0000,0,8'h5A); acc(16'h0001,0,8'hA5);
    `CHK(outReady,1'b1)
    i_bwm_dsp_model.get(w); `CHK(w,16'hA55A)
    `CHK(outReady,1'b0)
  end endtask
  task t_in; begin
    i_bwm_dsp_model.put(16'hC31E); `CHK(inReady,1'b1)
    acc(16'h0002,1,8'h00); `CHK(b,8'h01)
    acc(16'h0000,1,8'h00); `CHK(b,8'h1E)
    acc(16'h0001,1,8'h00); `CHK(b,8'hC3)
    `CHK(inReady,1'b0)
    acc(16'h0007,1,8'h00); `CHK(b,8'h00)
  end endtask
  task t_fault; begin
    acc(16'h0000,0,8'h01); acc(16'h0001,0,8'h02);
    repeat(5) @(negedge clk); `CHK(commFault,1'b0)
    repeat(10) @(negedge clk); `CHK(commFault,1'b1)
    acc(16'h0002,1,8'h00); `CHK(b,8'h06)
    i_bwm_dsp_model.get(w); `CHK(w,16'h0201)
    @(negedge clk) faultClr=1; @(negedge clk) faultClr=0;
    `CHK(commFault,1'b0)
  end endtask
  task complete_run; begin
    if (failures==0 && checks>0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish; end endtask
  initial begin
    repeat(16) @(negedge clk); nrst=1;
    t_out; t_in; t_fault; complete_run;
  end
  initial begin #100000; failures++; complete_run; end
endmodule
bind bwm_bridge bwm_monitor #(.TW(TW)) i_bwm_monitor(.*);
